//--- verilog/buck_voltage_select_regs.sv
// Converter two ceiling and converter three operating point registers on Avalon-MM
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "buck_cfg.svh"
module buck_voltage_select_regs #(
  parameter int CODE_W = `CODE_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [`ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] otp_ceiling_default,
  input wire logic [7:0] otp_operating_default,
  input wire logic [CODE_W-1:0] conv_two_operating_reg,
  input wire logic [CODE_W-1:0] conv_two_scaling_reg,
  input wire logic [CODE_W-1:0] conv_three_scaling_reg,
  input wire logic [1:0] conv_three_span,
  input wire logic setup_strap_b,
  input wire logic conv_three_source_pin,
  output buck_pkg::voltage_point_t conv_two_op_point,
  output buck_pkg::voltage_point_t conv_two_scale_point,
  output buck_pkg::voltage_point_t conv_three_point
);
  import buck_pkg::*;

  logic [7:0] ceiling_reg;
  logic [7:0] ceiling_next;
  logic [7:0] operating_reg;
  logic [7:0] operating_next;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic strap_s1_reg;
  logic strap_s2_reg;
  voltage_point_t two_op_reg;
  voltage_point_t two_scale_reg;
  voltage_point_t three_reg;

  // Bus decode
  wire req = avs_read | avs_write;
  wire accept = req & ack_reg;
  wire [5:0] word_idx = avs_address[`ADDR_W-1:2];
  wire hit_ceiling = word_idx == `IDX_CEILING;
  wire hit_operating = word_idx == `IDX_OPERATING;
  wire hit_status = word_idx == `IDX_STATUS;
  wire lane0 = avs_byteenable[0];
  wire wr_ceiling = accept & avs_write & lane0 & hit_ceiling;
  wire wr_operating = accept & avs_write & lane0 & hit_operating;

  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata = rdata_reg;

  // Ceiling field and lock
  wire [CODE_W-1:0] ceiling_code = ceiling_reg[CODE_W-1:0];
  wire [1:0] two_span = ceiling_reg[`SPAN_LSB+1:`SPAN_LSB];
  wire locked = (ceiling_code != `CODE_ALL_ONES) && (ceiling_code != `CODE_ALL_ZERO); // [R3]

  // Locked register keeps its value; the lock can never be undone by software
  assign ceiling_next = (wr_ceiling && !locked) ? avs_writedata[7:0] : ceiling_reg; // [R3] [R10]
  // Top bit is read-only and always zero
  assign operating_next = wr_operating ? {1'b0, avs_writedata[6:0]} : operating_reg; // [R9]

  // Converter two clamp
  wire [CODE_W-1:0] two_op_code =
    (conv_two_operating_reg > ceiling_code) ? ceiling_code : conv_two_operating_reg; // [R2]
  wire [CODE_W-1:0] two_scale_code =
    (conv_two_scaling_reg > ceiling_code) ? ceiling_code : conv_two_scaling_reg; // [R2]

  // Converter three source choice; strap low hands the choice to the pin
  wire source_bit = operating_reg[`SRC_BIT];
  wire pin_mode = ~strap_s2_reg & pin_s2_reg; // [R7]
  wire use_scaling = source_bit | pin_mode; // [R5] [R6]
  wire [CODE_W-1:0] three_code = use_scaling ? conv_three_scaling_reg : operating_reg[CODE_W-1:0];

  select_status_t status_word;
  assign status_word = '{locked: locked, pin_level: pin_s2_reg, strap_level: strap_s2_reg,
                         from_scaling: use_scaling};

  wire [31:0] read_mux =
    hit_ceiling ? {24'h000000, ceiling_reg} :
    hit_operating ? {24'h000000, operating_reg} :
    hit_status ? {28'h0000000, status_word} : 32'h00000000;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ceiling_reg <= otp_ceiling_default; // [R4]
      operating_reg <= {1'b0, otp_operating_default[6:0]}; // [R4]
    end else begin
      ceiling_reg <= ceiling_next;
      operating_reg <= operating_next;
    end
  end

  // One wait cycle per access; read data prepared while waitrequest is high
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (avs_read && !ack_reg) begin
        rdata_reg <= read_mux;
      end
    end
  end

  // Pins arrive from outside the clock domain
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      strap_s1_reg <= 1'b1;
      strap_s2_reg <= 1'b1;
    end else begin
      pin_s1_reg <= conv_three_source_pin;
      pin_s2_reg <= pin_s1_reg;
      strap_s1_reg <= setup_strap_b;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      two_op_reg <= '0;
      two_scale_reg <= '0;
      three_reg <= '0;
    end else begin
      two_op_reg <= '{span: two_span, code: two_op_code}; // [R1] [R2]
      two_scale_reg <= '{span: two_span, code: two_scale_code}; // [R1] [R2]
      three_reg <= '{span: conv_three_span, code: three_code}; // [R8]
    end
  end

  assign conv_two_op_point = two_op_reg;
  assign conv_two_scale_point = two_scale_reg;
  assign conv_three_point = three_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Gated on resetn: points still hold reset zeros one edge after release
  a_span_follows_ceiling: assert property ( // [R1]
    resetn |=> conv_two_op_point.span == $past(ceiling_reg[7:6])
      && conv_two_scale_point.span == $past(ceiling_reg[7:6]))
    else $error("converter two span does not follow ceiling register");

  a_clamp_two_op: assert property ( // [R2]
    resetn && conv_two_operating_reg > ceiling_code |=> conv_two_op_point.code == $past(ceiling_code))
    else $error("converter two operating code not clamped");

  a_clamp_pass_scale: assert property ( // [R2]
    resetn && conv_two_scaling_reg <= ceiling_code |=> conv_two_scale_point.code == $past(conv_two_scaling_reg))
    else $error("converter two scaling code wrongly altered");

  a_clamp_two_scale: assert property ( // [R2]
    resetn && conv_two_scaling_reg > ceiling_code |=> conv_two_scale_point.code == $past(ceiling_code))
    else $error("converter two scaling code not clamped");

  a_clamp_pass_op: assert property ( // [R2]
    resetn && conv_two_operating_reg <= ceiling_code |=> conv_two_op_point.code == $past(conv_two_operating_reg))
    else $error("converter two operating code wrongly altered");

  a_lock_holds_value: assert property ( // [R3]
    locked |=> $stable(ceiling_reg))
    else $error("locked ceiling register changed");

  a_unlocked_write_lands: assert property ( // [R10]
    wr_ceiling && !locked |=> ceiling_reg == $past(avs_writedata[7:0]))
    else $error("unlocked ceiling write lost");

  a_locked_write_dropped: assert property ( // [R10]
    wr_ceiling && locked |=> ceiling_reg == $past(ceiling_reg))
    else $error("write to locked ceiling register landed");

  a_lock_engages: assert property ( // [R3]
    wr_ceiling && !locked && avs_writedata[5:0] != `CODE_ALL_ONES
      && avs_writedata[5:0] != `CODE_ALL_ZERO |=> locked)
    else $error("intermediate ceiling code did not lock");

  // Own disable so the check stays live while reset is held
  a_reset_loads_defaults: assert property ( // [R4]
    @(posedge clk_sys) disable iff (1'b0) !resetn |=> ceiling_reg == $past(otp_ceiling_default)
      && operating_reg[6:0] == $past(otp_operating_default[6:0]))
    else $error("reset did not load programmed defaults");

  a_source_operating: assert property ( // [R5]
    resetn && !use_scaling |=> conv_three_point.code == $past(operating_reg[5:0]))
    else $error("converter three not taken from operating register");

  a_source_scaling: assert property ( // [R6]
    resetn && source_bit |=> conv_three_point.code == $past(conv_three_scaling_reg))
    else $error("converter three not taken from scaling register");

  a_pin_choice: assert property ( // [R7]
    resetn && !source_bit && !strap_s2_reg && pin_s2_reg |=> conv_three_point.code == $past(conv_three_scaling_reg))
    else $error("source pin ignored with strap low");

  a_pin_needs_strap: assert property ( // [R5] [R7]
    resetn && !source_bit && strap_s2_reg |=> conv_three_point.code == $past(operating_reg[5:0]))
    else $error("source pin acted with strap high");

  a_three_span: assert property ( // [R8]
    resetn |=> conv_three_point.span == $past(conv_three_span))
    else $error("converter three span mismatch");

  a_rsvd_write_zero: assert property ( // [R9]
    wr_operating |=> !operating_reg[`RSVD_BIT])
    else $error("reserved operating bit stored as one");

  a_rsvd_reads_zero: assert property ( // [R9]
    avs_read && !ack_reg && hit_operating |=> !avs_readdata[7] ##0 !avs_waitrequest)
    else $error("reserved bit read as one or answer late");

  c_lock_write: cover property (wr_ceiling && locked);
  c_pin_select: cover property (!strap_s2_reg && pin_s2_reg && !source_bit);
  c_clamp_active: cover property (conv_two_operating_reg > ceiling_code);
  c_read_status: cover property (accept && avs_read && hit_status);
  c_source_bit_scaling: cover property (source_bit && !pin_mode);
endmodule : buck_voltage_select_regs

//--- pkg/buck_cfg.svh
// Offsets, field positions, lock codes and timing counts for the buck voltage select registers
// Functional notes
// [R1] Ceiling register top two bits choose converter two output span.
// [R2] Converter two codes above the ceiling code are replaced by the ceiling.
// [R3] Ceiling code other than all-ones or all-zeros locks span and ceiling.
// [R4] Reset reloads ceiling and operating registers from programmed defaults.
// [R5] Source bit zero: converter three uses its operating register code.
// [R6] Source bit one: converter three uses its scaling register code.
// [R7] Host keeps source bit zero when strap low so the pin decides.
// [R8] Converter three six-bit code is read against its selected span.
// [R9] Operating register top bit reads zero; writes to it are dropped.
// [R10] While locked, host writes to span and ceiling are ignored.
`ifndef BUCK_CFG_SVH
`define BUCK_CFG_SVH
`define IDX_CEILING 6'h09
`define IDX_OPERATING 6'h0a
`define IDX_STATUS 6'h10
`define ADDR_W 8
`define CODE_W 6
`define SPAN_LSB 6
`define SRC_BIT 6
`define RSVD_BIT 7
`define CODE_ALL_ONES 6'h3f
`define CODE_ALL_ZERO 6'h00
`define ACK_WAIT_CYCLES 1
`endif

//--- pkg/buck_pkg.sv
// Types shared by the buck voltage select register logic
package buck_pkg;
  typedef struct packed {
    logic [1:0] span;
    logic [5:0] code;
  } voltage_point_t;
  typedef struct packed {
    logic locked;
    logic pin_level;
    logic strap_level;
    logic from_scaling;
  } select_status_t;
endpackage : buck_pkg

//--- test/host_bus_model.sv
// Host model that issues register requests on the Avalon-MM bus
`timescale 1ns/10ps
module host_bus_model (
  input wire logic clk_sys,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address = 8'h00,
  output logic avs_read = 1'b0,
  output logic avs_write = 1'b0,
  output logic [31:0] avs_writedata = 32'h0,
  output logic [3:0] avs_byteenable = 4'hf
);
  // Leading edge keeps back-to-back calls off one time step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : xfer
endmodule : host_bus_model

//--- test/tb.sv
// Self-checking bench for the buck voltage select registers
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  import buck_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] op2 = 6'h3e;
  logic [5:0] sc2 = 6'h10;
  logic [5:0] sc3 = 6'h2a;
  logic [1:0] span3 = 2'b01;
  logic strap_b = 1'b1;
  logic pin = 1'b0;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic avs_waitrequest;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [3:0] avs_byteenable;
  voltage_point_t p2o;
  voltage_point_t p2s;
  voltage_point_t p3;
  logic [7:0] q;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  initial forever #20 clk_sys = ~clk_sys;
  buck_voltage_select_regs u_buck_voltage_select_regs (.clk_sys, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .otp_ceiling_default(8'hbf), .otp_operating_default(8'hf5), .conv_two_operating_reg(op2),
    .conv_two_scaling_reg(sc2), .conv_three_scaling_reg(sc3), .conv_three_span(span3),
    .setup_strap_b(strap_b), .conv_three_source_pin(pin), .conv_two_op_point(p2o),
    .conv_two_scale_point(p2s), .conv_three_point(p3));
  host_bus_model u_host (.clk_sys, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable);
  task finish_test;
    $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // Run needs under a hundred cycles; 2000-cycle ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    u_host.xfer(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask : rd_chk
  // Settle time covers the point register and the pin synchronisers
  task wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, q);
    repeat (4) @(posedge clk_sys);
  endtask : wr
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    rd_chk(8'h24, 8'hbf);
    rd_chk(8'h28, 8'h75);
    `CHK(p2o, 8'hbe)
    `CHK(p2s, 8'h90)
    `CHK(p3, 8'h6a)
    wr(8'h24, 8'h40);
    `CHK(p2o, 8'h40)
    wr(8'h24, 8'hd0);
    `CHK(p2o, 8'hd0)
    `CHK(p2s, 8'hd0)
    wr(8'h24, 8'h3f);
    rd_chk(8'h24, 8'hd0);
    wr(8'h28, 8'h95);
    rd_chk(8'h28, 8'h15);
    `CHK(p3, 8'h55)
    pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK(p3, 8'h55)
    // Source bit stays 0 so the pin decides
    strap_b <= 1'b0;
    span3 <= 2'b10;
    repeat (4) @(posedge clk_sys);
    `CHK(p3, 8'haa)
    rd_chk(8'h40, 8'h0d);
    rd_chk(8'h3c, 8'h00);
    finish_test();
  end
endmodule : tb
